/* File: rtl/aux_pin_defines.svh */
`ifndef AUX_PIN_DEFINES_SVH
`define AUX_PIN_DEFINES_SVH

// register indexes; byte address is four times the index
`define AUX_PIN_7_0_CTRL_IDX 8'hd8
`define AUX_PIN_7_1_CTRL_IDX 8'hd9
`define AUX_PIN_7_2_CTRL_IDX 8'hda
`define AUX_PIN_7_3_CTRL_IDX 8'hdb
`define AUX_PIN_7_4_CTRL_IDX 8'hdc
`define AUX_PIN_7_5_CTRL_IDX 8'hdd
`define AUX_PIN_7_6_CTRL_IDX 8'hde
`define AUX_PIN_7_7_CTRL_IDX 8'hdf

// block-local registers beside the pin controls
`define AUX_PIN_DATA_IDX 8'he8
`define AUX_PIN_STATUS_IDX 8'he9
`define AUX_PIN_MASK_IDX 8'hea

// pin control reset value and field positions
`define PIN_CTRL_RESET 8'h01
`define PIN_CTRL_FUNC_LSB 3
`define PIN_CTRL_FUNC_MSB 4

// pins whose serial function is an output of the serial port (tx, rts, dtr)
`define SERIAL_OUT_MASK 8'ha8
// level handed to serial inputs that are not routed to their pin
`define SERIAL_IDLE 1'b1

`endif

/* File: rtl/aux_pin_pkg.sv */
package aux_pin_pkg;

  // function select codes
  typedef enum logic [1:0] {
    FUNC_SERIAL = 2'b00,
    FUNC_GPIO = 2'b01,
    FUNC_RSVD2 = 2'b10,
    FUNC_RSVD3 = 2'b11
  } pin_func_t;

  // one pin control byte, msb first
  typedef struct packed {
    logic open_coll;
    logic int_en2;
    logic rsvd5;
    pin_func_t func;
    logic int_en1;
    logic invert;
    logic dir_in;
  } pin_ctrl_t;

  // pad drive pair
  typedef struct packed {
    logic o;
    logic oe;
  } pad_drive_t;

endpackage : aux_pin_pkg

/* File: rtl/aux_pin_cell.sv */
`timescale 1ns/1ps
`include "aux_pin_defines.svh"

module aux_pin_cell
  import aux_pin_pkg::*;
#(
  parameter bit SERIAL_OUT = 1'b0
) (
  input wire pin_ctrl_t ctrl, // control byte of this pin
  input wire logic gp_out, // general-purpose data value
  input wire logic serial_src, // serial port output for this pin
  input wire logic pad_in, // pad level
  output pad_drive_t drive, // pad value and enable
  output logic serial_in, // value handed to serial port input
  output logic gp_in, // pad level after polarity
  output logic gp_in_sel // pin is a general-purpose input
);

  logic val;
  logic drv;

  // function steering; reserved codes leave the pad released
  always_comb begin
    val = 1'b0;
    drv = 1'b0;
    if (ctrl.func == FUNC_SERIAL && SERIAL_OUT) begin
      val = serial_src;
      drv = 1'b1;
    end else if (ctrl.func == FUNC_GPIO && !ctrl.dir_in) begin
      val = gp_out ^ ctrl.invert;
      drv = 1'b1;
    end
    // open collector only ever pulls low
    drive.o = val & ~ctrl.open_coll;
    drive.oe = drv & (~ctrl.open_coll | ~val);
    serial_in = (ctrl.func == FUNC_SERIAL && !SERIAL_OUT) ? pad_in : `SERIAL_IDLE;
    gp_in = pad_in ^ ctrl.invert;
    gp_in_sel = (ctrl.func == FUNC_GPIO) && ctrl.dir_in;
  end

endmodule : aux_pin_cell

/* File: rtl/aux_port7_pin_function_select.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "aux_pin_defines.svh"

module aux_port7_pin_function_select
  import aux_pin_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int ADDR_W = 12
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst_n, // power-on reset, async, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  input wire logic [7:0] pad_in, // pin levels
  output logic [7:0] pad_out, // pin drive values
  output logic [7:0] pad_oe, // pin drive enables
  input wire logic transmit_line_port2, // serial tx from port 2
  input wire logic request_send_port2, // serial rts from port 2
  input wire logic terminal_ready_port2, // serial dtr from port 2
  output logic ring_indicator_port2, // ring indicator to port 2
  output logic carrier_detect_port2, // carrier detect to port 2
  output logic receive_line_port2, // rx data to port 2
  output logic set_ready_port2, // data set ready to port 2
  output logic clear_send_port2, // clear to send to port 2
  output logic irq, // masked pin event interrupt
  output logic combined_irq1, // first combined interrupt
  output logic combined_irq2 // second combined interrupt
);

  localparam logic [7:0] SER_OUT = `SERIAL_OUT_MASK;

  // the serial mapping is fixed to eight pins
  if (NUM_PINS != 8) begin : g_chk_pins
    $error("NUM_PINS must be 8");
  end
  if (ADDR_W < 10) begin : g_chk_addr
    $error("ADDR_W must be at least 10");
  end

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction : byte_addr

  pin_ctrl_t ctrl_q [NUM_PINS];
  logic [7:0] data_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [7:0] uart_in_q;
  logic [7:0] pad_out_q;
  logic [7:0] pad_oe_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic irq_q;
  logic irq1_q;
  logic irq2_q;
  logic boot_q;

  pad_drive_t drv [NUM_PINS];
  logic [7:0] ser_in;
  logic [7:0] gp_in;
  logic [7:0] gp_in_sel;
  logic [7:0] ser_src;
  logic [7:0] en1_vec;
  logic [7:0] en2_vec;
  logic [7:0] ev;
  logic [7:0] idx;
  logic [2:0] pin_sel;
  logic is_ctrl;
  logic hit;
  logic [7:0] rd_val;
  logic wr_en;

  // serial outputs on pins 3, 5 and 7; others unused by the cells
  assign ser_src = {terminal_ready_port2, `SERIAL_IDLE, request_send_port2, `SERIAL_IDLE,
                    transmit_line_port2, `SERIAL_IDLE, `SERIAL_IDLE, `SERIAL_IDLE};

  // one cell per pin does the function steering
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    aux_pin_cell #(
      .SERIAL_OUT(SER_OUT[i])
    ) u_cell (
      .ctrl(ctrl_q[i]),
      .gp_out(data_q[i]),
      .serial_src(ser_src[i]),
      .pad_in(pad_in[i]),
      .drive(drv[i]),
      .serial_in(ser_in[i]),
      .gp_in(gp_in[i]),
      .gp_in_sel(gp_in_sel[i])
    );
    assign en1_vec[i] = ctrl_q[i].int_en1;
    assign en2_vec[i] = ctrl_q[i].int_en2;
  end

  // address decode; misaligned or out-of-range addresses miss
  assign idx = paddr[9:2];
  assign pin_sel = 3'(idx - `AUX_PIN_7_0_CTRL_IDX);
  assign is_ctrl = (idx >= `AUX_PIN_7_0_CTRL_IDX) && (idx <= `AUX_PIN_7_7_CTRL_IDX);
  always_comb begin
    hit = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `AUX_PIN_DATA_IDX: rd_val = data_q;
      `AUX_PIN_STATUS_IDX: rd_val = status_q;
      `AUX_PIN_MASK_IDX: rd_val = mask_q;
      default: begin
        if (is_ctrl) begin
          rd_val = ctrl_q[pin_sel];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    // shift rather than slice so the narrowest legal bus width still elaborates
    if (paddr[1:0] != 2'b00 || (paddr >> 10) != '0) begin
      hit = 1'b0;
    end
  end

  // a write lands only at the completing edge; a cleared pstrb[0] drops it quietly
  assign wr_en = psel & penable & pready_q & pwrite & hit & pstrb[0];

  // apb answer: ready one cycle after setup, read data captured at setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable;
      if (psel && !penable) begin
        prdata_q <= (hit && !pwrite) ? {{24{1'b0}}, rd_val} : 32'h0000_0000;
        pslverr_q <= ~hit;
      end else begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // pin control registers; reserved codes are stored as written and release the pad
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        ctrl_q[i] <= pin_ctrl_t'(`PIN_CTRL_RESET);
      end
    end else if (wr_en && is_ctrl) begin
      ctrl_q[pin_sel] <= pin_ctrl_t'(pwdata[7:0]);
    end
  end

  // data value: inputs sample the pad every cycle, outputs take software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 8'h00;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (gp_in_sel[i]) begin
          data_q[i] <= gp_in[i];
        end else if (wr_en && idx == `AUX_PIN_DATA_IDX) begin
          data_q[i] <= pwdata[i];
        end
      end
    end
  end

  // input change events; set beats a write-one clear in the same cycle
  assign ev = gp_in_sel & (gp_in ^ data_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
      mask_q <= 8'h00;
    end else begin
      if (wr_en && idx == `AUX_PIN_STATUS_IDX) begin
        status_q <= (status_q & ~pwdata[7:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
      if (wr_en && idx == `AUX_PIN_MASK_IDX) begin
        mask_q <= pwdata[7:0];
      end
    end
  end

  // registered pads and serial inputs; reserved codes give idle serial levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= 8'h00;
      pad_oe_q <= 8'h00;
      uart_in_q <= 8'hff;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pad_out_q[i] <= drv[i].o;
        pad_oe_q[i] <= drv[i].oe;
      end
      uart_in_q <= ser_in;
    end
  end

  // interrupt outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
      irq1_q <= |(status_q & en1_vec);
      irq2_q <= |(status_q & en2_vec);
    end
  end

  // marks the first edge after reset release, for checking only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign ring_indicator_port2 = uart_in_q[0];
  assign carrier_detect_port2 = uart_in_q[1];
  assign receive_line_port2 = uart_in_q[2];
  assign set_ready_port2 = uart_in_q[4];
  assign clear_send_port2 = uart_in_q[6];
  assign irq = irq_q;
  assign combined_irq1 = irq1_q;
  assign combined_irq2 = irq2_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_write;
    psel && penable && pready && pwrite && pstrb[0] && paddr == byte_addr(`AUX_PIN_7_0_CTRL_IDX);
  endsequence

  a_ctrl_reset: assert property (boot_q |-> ctrl_q[0] == 8'h01 && ctrl_q[7] == 8'h01)
    else $error("pin control not at reset value");

  a_ctrl_write: assert property (s_setup ##1 s_ctrl_write |=> ctrl_q[0] == $past(pwdata[7:0]))
    else $error("pin control write lost");

  a_irq_combined: assert property (##1 combined_irq1 == $past(|(status_q & en1_vec))
    && combined_irq2 == $past(|(status_q & en2_vec)))
    else $error("combined interrupt wrong");

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_chk
    if (SER_OUT[i]) begin : g_out
      a_serial_out: assert property (ctrl_q[i].func == FUNC_SERIAL && !ctrl_q[i].open_coll
        |=> pad_oe[i] && pad_out[i] == $past(ser_src[i]))
        else $error("serial output not on pad");
    end else begin : g_in
      a_serial_in: assert property (ctrl_q[i].func == FUNC_SERIAL
        |=> uart_in_q[i] == $past(pad_in[i]))
        else $error("serial input not from pad");
      a_serial_idle: assert property (ctrl_q[i].func != FUNC_SERIAL |=> uart_in_q[i] == `SERIAL_IDLE)
        else $error("serial input not idle");
    end
    a_gpio_drive: assert property (ctrl_q[i].func == FUNC_GPIO && !ctrl_q[i].dir_in
      && !ctrl_q[i].open_coll |=> pad_oe[i] && pad_out[i] == $past(data_q[i] ^ ctrl_q[i].invert))
      else $error("gpio output drive wrong");
    a_gpio_input: assert property (ctrl_q[i].func == FUNC_GPIO && ctrl_q[i].dir_in
      |=> !pad_oe[i] && data_q[i] == $past(pad_in[i] ^ ctrl_q[i].invert))
      else $error("gpio input not sampled");
    a_open_coll: assert property (ctrl_q[i].open_coll |=> !(pad_oe[i] && pad_out[i]))
      else $error("open collector drove high");
    a_event_sticky: assert property ($past(ev[i]) |-> status_q[i])
      else $error("pin event lost");
  end

endmodule : aux_port7_pin_function_select

/* File: sim/aux_pin_partner.sv */
`timescale 1ns/1ps

// far side of the pins: whatever the outside world puts on a pin the module has released
module aux_pin_partner (
  input wire logic [7:0] pad_out, // module drive value
  input wire logic [7:0] pad_oe, // module drive enable
  input wire logic [7:0] ext_lvl, // level of the outside driver or pull
  output logic [7:0] pad_in // resolved pin level
);
  // a released pin takes ext_lvl, never the old driven value, so a missed release shows up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : aux_pin_partner

/* File: sim/aux_port7_pin_function_select_tb_top.sv */
`timescale 1ns/1ps
`include "aux_pin_defines.svh"

module aux_port7_pin_function_select_tb_top;
  import aux_pin_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, irq1, irq2, err;
  logic tx = 1, rts = 1, dtr = 1, ri, cd, rx, dsr, cts;
  logic [7:0] pad_in, pad_out, pad_oe, ext = '0;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  wire [4:0] ser_in = {cts, dsr, rx, cd, ri};

  always #5 clk = ~clk;

  // cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  aux_port7_pin_function_select aux_port7_pin_function_select_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .transmit_line_port2(tx), .request_send_port2(rts), .terminal_ready_port2(dtr),
    .ring_indicator_port2(ri), .carrier_detect_port2(cd), .receive_line_port2(rx), .set_ready_port2(dsr),
    .clear_send_port2(cts), .irq(irq), .combined_irq1(irq1), .combined_irq2(irq2));

  aux_pin_partner aux_pin_partner_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_all(input logic [7:0] v);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'(`AUX_PIN_7_0_CTRL_IDX + i), {24'h0, v});
    repeat (3) @(posedge clk);
  endtask : set_all

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(`AUX_PIN_7_0_CTRL_IDX + i), '0);
      chk(rd, 32'h0000_0001);
    end
    apb(1'b0, 8'he0, '0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  // serial function: inputs follow their pins, outputs drive pins 3, 5 and 7
  task automatic t_serial();
    for (int k = 0; k < 2; k++) begin
      ext <= k ? 8'haa : 8'h55;
      tx <= k[0];
      rts <= ~k[0];
      dtr <= k[0];
      repeat (3) @(posedge clk);
      chk(ser_in, {ext[6], ext[4], ext[2], ext[1], ext[0]});
      chk({pad_oe[7], pad_oe[5], pad_oe[3]}, 3'b111);
      chk({pad_out[7], pad_out[5], pad_out[3]}, {dtr, rts, tx});
    end
    $display("test serial done");
  endtask : t_serial

  task automatic t_gpio_out();
    ext <= 8'h00;
    set_all(8'h08);
    apb(1'b1, `AUX_PIN_DATA_IDX, 32'h0000_005a);
    repeat (3) @(posedge clk);
    chk(pad_oe, 8'hff);
    chk(pad_out, 8'h5a);
    chk(ser_in, 5'h1f);
    set_all(8'h0a);
    chk(pad_out, 8'ha5);
    set_all(8'h88);
    chk(pad_oe, 8'ha5);
    chk(pad_out & pad_oe, 8'h00);
    $display("test gpio output done");
  endtask : t_gpio_out

  task automatic t_gpio_in();
    set_all(8'h4d);
    apb(1'b1, `AUX_PIN_STATUS_IDX, 32'h0000_00ff);
    apb(1'b1, `AUX_PIN_MASK_IDX, 32'h0000_0001);
    chk(pad_oe, 8'h00);
    chk({irq, irq1, irq2}, 3'b000);
    ext <= 8'h03;
    repeat (4) @(posedge clk);
    apb(1'b0, `AUX_PIN_DATA_IDX, '0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, `AUX_PIN_STATUS_IDX, '0);
    chk(rd, 32'h0000_0003);
    chk({irq, irq1, irq2}, 3'b111);
    apb(1'b1, `AUX_PIN_MASK_IDX, 32'h0000_0000);
    apb(1'b1, `AUX_PIN_STATUS_IDX, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk({irq, irq1, irq2}, 3'b000);
    set_all(8'h09);
    ext <= 8'h00;
    repeat (4) @(posedge clk);
    chk({irq1, irq2}, 2'b00);
    set_all(8'h0b);
    apb(1'b0, `AUX_PIN_DATA_IDX, '0);
    chk(rd, 32'h0000_00ff);
    $display("test gpio input done");
  endtask : t_gpio_in

  // reserved select codes release the pin and idle the serial inputs
  task automatic t_reserved();
    for (int c = 2; c < 4; c++) begin
      set_all({3'b000, 2'(c), 3'b000});
      chk(pad_oe, 8'h00);
      chk(ser_in, 5'h1f);
    end
    $display("test reserved done");
  endtask : t_reserved

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // reset held for five cycles, then each scenario in turn
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_serial();
    t_gpio_out();
    t_gpio_in();
    t_reserved();
    stop_test();
  end
endmodule : aux_port7_pin_function_select_tb_top
